// ==== hdl/ckg_top.sv ====
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "ckg_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - aux mux is plain, may glitch
// - ref and sys slices add glitchless mux
// - two source cycles stop, two restart
// - readable one-hot status of used source
// - divide by one or 2.0 upward
// - fraction alternates two neighbouring integer periods
// - new divisor taken at cycle end
// - enable change taken at cycle end
// - ref and sys have no kill; only deep stop disables them
// - kill halts at once, mid-cycle
// - divider counts input rising edges only
// - odd divisor correction uses falling edge
// - each destination has sleep enable; all but clocks branch have awake enable
// - all destination enable bits reset to one
// - bus fabric branch always on when awake
// - clocks-block branch has no awake bit
// - pin clock and cores never gated
// - sleep when both cores asleep, DMA idle
// - sleep swaps awake set for sleep set
// - ref from ring oscillator, sys from ref
// - divisor integer 31:8, fraction 7:0
// - status one-hot, bit zero is source zero
module ckg_top
  import ckg_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic [`CKG_AW-1:0]   avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic                 ringOscillator,
  input  wire logic                 crystalOscillator,
  input  wire logic                 pinClockInA,
  input  wire logic                 pinClockInB,
  input  wire logic                 core0Sleep,
  input  wire logic                 core1Sleep,
  input  wire logic                 dmaBusy,
  input  wire logic                 deepStopState,
  output logic                      refClk,
  output logic                      sysClk,
  output logic                      pinClockOutputA,
  output logic [`CKG_NDEST-1:0]     sysDestClk,
  output logic                      systemSleep
);

  //////////////////////////////////////////////////////////////////////////////
  // state

  localparam ckg_top_state_t TOP_RST = '{
    refDiv:   `CKG_DIV_RESET,
    sysDiv:   `CKG_DIV_RESET,
    pinDiv:   `CKG_DIV_RESET,
    wakeEn:   `CKG_WAKE_RESET,
    sleepEn:  `CKG_SLEEP_RESET,
    gate:     `CKG_SLEEP_RESET,
    waitReq:  1'b1,
    default:  '0
  };

  ckg_top_state_t s, n;

  logic       refAuxLvl;
  logic       sysAuxLvl;
  logic       pinAuxLvl;
  logic [1:0] ringE;
  logic [1:0] refAuxE;
  logic [1:0] sysAuxE;
  logic [1:0] pinAuxE;
  logic [1:0] refOutE;
  logic [1:0] refIn;
  logic [1:0] sysIn;
  logic [1:0] refSel;
  logic [1:0] sysSel;
  logic       alwaysOnEn;
  logic       noKill;
  logic       noDc50;
  logic       pinRun;
  logic       refRun;
  logic       sysRun;
  logic       req;
  logic [3:0] destEn;
  logic [31:0] rd;

  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = s.waitReq;
  assign systemSleep     = s.sleeping;
  assign sysDestClk      = s.dest;

  //////////////////////////////////////////////////////////////////////////////
  // auxiliary muxes: plain selects on the filtered levels (pin mux also on refClk and sysClk), so a select
  // change may produce a runt edge; software must park the slice first

  always_comb begin
    unique case (s.refAux)
      2'h0: refAuxLvl = s.lvl[`CKG_SRC_CRYS];
      2'h1: refAuxLvl = s.lvl[`CKG_SRC_PINA];
      2'h2: refAuxLvl = s.lvl[`CKG_SRC_PINB];
      2'h3: refAuxLvl = 1'b0;
    endcase
  end

  always_comb begin
    unique case (s.sysAux)
      2'h0: sysAuxLvl = s.lvl[`CKG_SRC_CRYS];
      2'h1: sysAuxLvl = s.lvl[`CKG_SRC_PINA];
      2'h2: sysAuxLvl = s.lvl[`CKG_SRC_PINB];
      2'h3: sysAuxLvl = s.lvl[`CKG_SRC_RING];
    endcase
  end

  always_comb begin
    case (s.pinAux)
      4'h0:    pinAuxLvl = s.lvl[`CKG_SRC_RING];
      4'h1:    pinAuxLvl = s.lvl[`CKG_SRC_CRYS];
      4'h2:    pinAuxLvl = s.lvl[`CKG_SRC_PINA];
      4'h3:    pinAuxLvl = s.lvl[`CKG_SRC_PINB];
      4'h4:    pinAuxLvl = refClk;
      4'h5:    pinAuxLvl = sysClk;
      default: pinAuxLvl = 1'b0;
    endcase
  end

  assign ringE   = ckgEdge(s.lvlPrev[`CKG_SRC_RING], s.lvl[`CKG_SRC_RING]);
  assign refAuxE = ckgEdge(s.refAuxPrev, refAuxLvl);
  assign sysAuxE = ckgEdge(s.sysAuxPrev, sysAuxLvl);
  assign pinAuxE = ckgEdge(s.pinAuxPrev, pinAuxLvl);
  assign refOutE = ckgEdge(s.refOutPrev, refClk);

  //////////////////////////////////////////////////////////////////////////////
  // reference slice: source 0 is the ring oscillator

  // only the deep stop state halts the always-on slices
  assign alwaysOnEn = ~deepStopState;
  assign noKill     = 1'b0;
  assign noDc50     = 1'b0;

  ckg_glitchless uRefMux (
    .core_clk (core_clk),
    .reset    (reset),
    .sel      (s.refGsel),
    .rise0    (ringE[1]),
    .fall0    (ringE[0]),
    .rise1    (refAuxE[1]),
    .fall1    (refAuxE[0]),
    .riseOut  (refIn[1]),
    .fallOut  (refIn[0]),
    .selected (refSel)
  );

  ckg_divider uRefDiv (
    .core_clk (core_clk),
    .reset    (reset),
    .srcRise  (refIn[1]),
    .srcFall  (refIn[0]),
    .enable   (alwaysOnEn),
    .kill     (noKill),
    .dc50     (noDc50),
    .divInt   (s.refDiv[31:8]),
    .divFrac  (s.refDiv[7:0]),
    .clkOut   (refClk),
    .running  (refRun)
  );

  //////////////////////////////////////////////////////////////////////////////
  // system slice: source 0 is the reference clock

  ckg_glitchless uSysMux (
    .core_clk (core_clk),
    .reset    (reset),
    .sel      (s.sysGsel),
    .rise0    (refOutE[1]),
    .fall0    (refOutE[0]),
    .rise1    (sysAuxE[1]),
    .fall1    (sysAuxE[0]),
    .riseOut  (sysIn[1]),
    .fallOut  (sysIn[0]),
    .selected (sysSel)
  );

  ckg_divider uSysDiv (
    .core_clk (core_clk),
    .reset    (reset),
    .srcRise  (sysIn[1]),
    .srcFall  (sysIn[0]),
    .enable   (alwaysOnEn),
    .kill     (noKill),
    .dc50     (noDc50),
    .divInt   (s.sysDiv[31:8]),
    .divFrac  (s.sysDiv[7:0]),
    .clkOut   (sysClk),
    .running  (sysRun)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pin clock slice: aux mux only, with enable, kill and correction

  ckg_divider uPinDiv (
    .core_clk (core_clk),
    .reset    (reset),
    .srcRise  (pinAuxE[1]),
    .srcFall  (pinAuxE[0]),
    .enable   (s.pinEn),
    .kill     (s.pinKill),
    .dc50     (s.pinDc50),
    .divInt   (s.pinDiv[31:8]),
    .divFrac  (s.pinDiv[7:0]),
    .clkOut   (pinClockOutputA),
    .running  (pinRun)
  );

  //////////////////////////////////////////////////////////////////////////////
  // destination enables

  always_comb begin
    if (s.sleeping) begin
      destEn = s.sleepEn;
    end else begin
      destEn = s.wakeEn;
      destEn[0] = 1'b1;
      destEn[1] = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register read view

  always_comb begin
    rd = 32'h0;
    unique case (avs_address)
      `CKG_REF_CTRL: begin
        rd[`CKG_CTRL_GSEL]       = s.refGsel;
        rd[`CKG_CTRL_AUX +: 2]   = s.refAux;
      end
      `CKG_REF_DIV:  rd = s.refDiv;
      `CKG_REF_SEL:  rd[1:0] = refSel;
      `CKG_SYS_CTRL: begin
        rd[`CKG_CTRL_GSEL]       = s.sysGsel;
        rd[`CKG_CTRL_AUX +: 2]   = s.sysAux;
      end
      `CKG_SYS_DIV:  rd = s.sysDiv;
      `CKG_SYS_SEL:  rd[1:0] = sysSel;
      `CKG_PIN_CTRL: begin
        rd[`CKG_CTRL_AUX +: 4]   = s.pinAux;
        rd[`CKG_CTRL_KILL]       = s.pinKill;
        rd[`CKG_CTRL_ENABLE]     = s.pinEn;
        rd[`CKG_CTRL_DC50]       = s.pinDc50;
      end
      `CKG_PIN_DIV:  rd = s.pinDiv;
      `CKG_WAKE_EN:  rd[3:0] = s.wakeEn;
      `CKG_SLEEP_EN: rd[3:0] = s.sleepEn;
      `CKG_STATUS: begin
        rd[0] = s.sleeping;
        rd[1] = pinRun;
        rd[2] = refRun;
        rd[3] = sysRun;
      end
      default:       rd = 32'h0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  assign req = avs_read | avs_write;

  always_comb begin
    n = s;

    // pin synchronisers: a change counts once stages two and three agree
    n.sy0 = {pinClockInB, pinClockInA, crystalOscillator, ringOscillator};
    n.sy1 = s.sy0;
    n.sy2 = s.sy1;
    for (int i = 0; i < 4; i++) begin
      if (s.sy1[i] == s.sy2[i]) n.lvl[i] = s.sy2[i];
    end
    n.lvlPrev    = s.lvl;
    n.refAuxPrev = refAuxLvl;
    n.sysAuxPrev = sysAuxLvl;
    n.pinAuxPrev = pinAuxLvl;
    n.refOutPrev = refClk;

    // system sleep follows the cores and DMA with no hysteresis
    n.sleeping = core0Sleep & core1Sleep & ~dmaBusy;

    // gates move only while the branch clock is low
    if (!sysClk) n.gate = destEn;
    n.dest = {`CKG_NDEST{sysClk}} & s.gate;

    // one wait cycle per access, then one cycle with waitrequest low
    n.waitReq = ~(req & s.waitReq);
    if (avs_read && s.waitReq) n.rdata = rd;

    if (avs_write && !s.waitReq) begin
      unique case (avs_address)
        `CKG_REF_CTRL: begin
          n.refGsel = avs_writedata[`CKG_CTRL_GSEL];
          n.refAux  = avs_writedata[`CKG_CTRL_AUX +: 2];
        end
        `CKG_REF_DIV:  n.refDiv = avs_writedata;
        `CKG_SYS_CTRL: begin
          n.sysGsel = avs_writedata[`CKG_CTRL_GSEL];
          n.sysAux  = avs_writedata[`CKG_CTRL_AUX +: 2];
        end
        `CKG_SYS_DIV:  n.sysDiv = avs_writedata;
        `CKG_PIN_CTRL: begin
          n.pinAux  = avs_writedata[`CKG_CTRL_AUX +: 4];
          n.pinKill = avs_writedata[`CKG_CTRL_KILL];
          n.pinEn   = avs_writedata[`CKG_CTRL_ENABLE];
          n.pinDc50 = avs_writedata[`CKG_CTRL_DC50];
        end
        `CKG_PIN_DIV:  n.pinDiv = avs_writedata;
        `CKG_WAKE_EN:  n.wakeEn = avs_writedata[3:0] & `CKG_WAKE_MASK;
        `CKG_SLEEP_EN: n.sleepEn = avs_writedata[3:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers; reset leaves ref on the ring oscillator, sys on ref

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) s <= TOP_RST;
    else       s <= n;
  end

  // cores take sysClk and the pin takes its slice output ungated

endmodule

// ==== pkg/ckg_consts.svh ====
`ifndef CKG_CONSTS_SVH
`define CKG_CONSTS_SVH

// register byte offsets
`define CKG_AW          6
`define CKG_REF_CTRL    6'h00
`define CKG_REF_DIV     6'h04
`define CKG_REF_SEL     6'h08
`define CKG_SYS_CTRL    6'h0c
`define CKG_SYS_DIV     6'h10
`define CKG_SYS_SEL     6'h14
`define CKG_PIN_CTRL    6'h18
`define CKG_PIN_DIV     6'h1c
`define CKG_WAKE_EN     6'h20
`define CKG_SLEEP_EN    6'h24
`define CKG_STATUS      6'h28

// control fields
`define CKG_CTRL_GSEL   0
`define CKG_CTRL_AUX    5
`define CKG_CTRL_KILL   10
`define CKG_CTRL_ENABLE 11
`define CKG_CTRL_DC50   12

// reset values
`define CKG_DIV_RESET   32'h0000_0100
`define CKG_WAKE_MASK   4'hd
`define CKG_WAKE_RESET  4'hd
`define CKG_SLEEP_RESET 4'hf
`define CKG_NDEST       4

// source indices
`define CKG_SRC_RING    0
`define CKG_SRC_CRYS    1
`define CKG_SRC_PINA    2
`define CKG_SRC_PINB    3

`endif

// ==== pkg/ckg_pkg.sv ====
package ckg_pkg;
  `include "ckg_consts.svh"

  typedef enum logic [1:0] {GM_IDLE, GM_STOP, GM_START} ckg_gm_phase_t;

  typedef struct packed {
    ckg_gm_phase_t phase;
    logic          cur;
    logic [1:0]    cnt;
    logic [1:0]    selected;
  } ckg_gm_state_t;

  typedef struct packed {
    logic [1:0]  enPipe;
    logic        run;
    logic [24:0] cnt;
    logic [24:0] per;
    logic [7:0]  acc;
    logic        out;
    logic        pend;
  } ckg_div_state_t;

  typedef struct packed {
    logic [3:0]  sy0, sy1, sy2, lvl, lvlPrev;
    logic        refAuxPrev, sysAuxPrev, pinAuxPrev, refOutPrev;
    logic        refGsel, sysGsel;
    logic [1:0]  refAux, sysAux;
    logic [3:0]  pinAux;
    logic        pinKill, pinEn, pinDc50;
    logic [31:0] refDiv, sysDiv, pinDiv;
    logic [3:0]  wakeEn, sleepEn, gate, dest;
    logic        sleeping, waitReq;
    logic [31:0] rdata;
  } ckg_top_state_t;

  // {rise, fall} of a level seen through its previous sample
  function automatic logic [1:0] ckgEdge(input logic prev, input logic cur);
    return {cur & ~prev, prev & ~cur};
  endfunction
endpackage

// ==== hdl/ckg_glitchless.sv ====
`timescale 1ns/10ps
`include "ckg_consts.svh"
module ckg_glitchless
  import ckg_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       sel,
  input  wire logic       rise0,
  input  wire logic       fall0,
  input  wire logic       rise1,
  input  wire logic       fall1,
  output logic            riseOut,
  output logic            fallOut,
  output logic [1:0]      selected
);
  ckg_gm_state_t s, n;
  logic          curRise, curFall;

  assign curRise  = s.cur ? rise1 : rise0;
  assign curFall  = s.cur ? fall1 : fall0;
  // incoming edges are swallowed until its two start cycles are done
  assign riseOut  = curRise & (s.phase != GM_START);
  assign fallOut  = curFall & (s.phase != GM_START);
  assign selected = s.selected;

  always_comb begin
    n = s;
    unique case (s.phase)
      GM_IDLE: if (sel != s.cur) begin
        n.phase = GM_STOP;
        n.cnt   = 2'h0;
      end
      GM_STOP: if (curFall) begin
        n.cnt = s.cnt + 2'h1;
        if (s.cnt == 2'h1) begin
          n.phase    = GM_START;
          n.cur      = sel;
          n.cnt      = 2'h0;
          n.selected = 2'h0;
        end
      end
      GM_START: if (curRise) begin
        n.cnt = s.cnt + 2'h1;
        if (s.cnt == 2'h1) begin
          n.phase    = GM_IDLE;
          n.selected = s.cur ? 2'h2 : 2'h1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) s <= '{phase: GM_IDLE, cur: 1'b0, cnt: 2'h0, selected: 2'h1};
    else       s <= n;
  end
endmodule

// ==== hdl/ckg_divider.sv ====
`timescale 1ns/10ps
`include "ckg_consts.svh"
module ckg_divider
  import ckg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        srcRise,
  input  wire logic        srcFall,
  input  wire logic        enable,
  input  wire logic        kill,
  input  wire logic        dc50,
  input  wire logic [23:0] divInt,
  input  wire logic [7:0]  divFrac,
  output logic             clkOut,
  output logic             running
);
  ckg_div_state_t s, n;
  logic [8:0]     sum;

  assign clkOut  = s.out;
  assign running = s.run;
  assign sum     = {1'b0, s.acc} + {1'b0, divFrac};

  always_comb begin
    n = s;
    if (srcRise) n.enPipe = {s.enPipe[0], enable};
    if (kill) begin
      n.run  = 1'b0;
      n.out  = 1'b0;
      n.pend = 1'b0;
      n.cnt  = 25'h0;
    end else if (srcRise) begin
      if (!s.run || s.cnt == s.per) begin
        // new divisor and enable only take hold here
        n.run  = s.enPipe[1];
        n.out  = s.enPipe[1];
        n.pend = 1'b0;
        n.cnt  = 25'h1;
        if (divInt == 24'h1) begin
          n.per = 25'h1;
        end else begin
          n.acc = sum[7:0];
          n.per = {divInt == 24'h0, divInt} + {24'h0, sum[8]};
        end
      end else begin
        if (s.cnt == (s.per >> 1)) begin
          if (dc50 && s.per[0]) n.pend = 1'b1;
          else                  n.out  = 1'b0;
        end
        n.cnt = s.cnt + 25'h1;
      end
    end else if (srcFall && (s.pend || (s.run && s.per == 25'h1))) begin
      n.out  = 1'b0;
      n.pend = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) s <= '{per: 25'h1, default: '0};
    else       s <= n;
  end
endmodule

// ==== tb/ckg_src_model.sv ====
`timescale 1ns/10ps
module ckg_src_model
  import ckg_pkg::*;
(
  input  wire logic       core_clk,
  output logic [3:0]      srcClk
);
  // ring, crystal, pin A, pin B half periods in core cycles
  localparam int HALF [4] = '{5, 6, 7, 9};
  int cnt [4] = '{0, 0, 0, 0};
  // one procedural driver; the port only mirrors it
  logic [3:0] lvl = 4'h0;

  assign srcClk = lvl;

  // free-running sources, all kept slower than core_clk/8 so the synchronisers see every level
  always @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (cnt[i] == HALF[i] - 1) begin
        cnt[i] <= 0;
        lvl[i] <= ~lvl[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule

// ==== tb/ckg_top_checker.sv ====
`timescale 1ns/10ps
`include "ckg_consts.svh"
module ckg_top_checker
  import ckg_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic [`CKG_AW-1:0]    avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [31:0]           avs_readdata,
  input  wire logic                  avs_waitrequest,
  input  wire logic                  core0Sleep,
  input  wire logic                  core1Sleep,
  input  wire logic                  dmaBusy,
  input  wire logic                  sysClk,
  input  wire logic                  pinClockOutputA,
  input  wire logic [`CKG_NDEST-1:0] sysDestClk,
  input  wire logic                  systemSleep
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////////
  sequence awakeLow;
    !systemSleep && !sysClk;
  endsequence
  sequence awakeHigh;
    !systemSleep && sysClk;
  endsequence
  sequence killWrite;
    avs_write && !avs_waitrequest && avs_address == `CKG_PIN_CTRL
      && avs_writedata[`CKG_CTRL_KILL];
  endsequence
  // gate reloads only in the low phase, so judge the high phase after a low one
  property alwaysGated(int i);
    awakeLow ##1 awakeHigh |=> sysDestClk[i];
  endproperty

  ////////////////////////////////////////////////////////////////////////////////
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one wait cycle");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_SLEEP_ENTRY: assert property (1'b1 |=> systemSleep == $past(core0Sleep && core1Sleep && !dmaBusy))
    else $error("system sleep does not follow cores and dma");
  AST_BUS_FABRIC: assert property (alwaysGated(0))
    else $error("bus fabric clock gated while awake");
  AST_CLOCKS_BRANCH: assert property (alwaysGated(1))
    else $error("clocks block branch gated while awake");
  AST_DEST_FOLLOW: assert property (|sysDestClk |-> $past(sysClk))
    else $error("destination clock high without system clock");
  AST_KILL_STOP: assert property (killWrite |-> ##2 (!pinClockOutputA) [*4])
    else $error("pin clock still running after kill");
  AST_SEL_ONEHOT: assert property (avs_read && !avs_waitrequest
      && (avs_address == `CKG_REF_SEL || avs_address == `CKG_SYS_SEL) |-> $onehot0(avs_readdata))
    else $error("selected source not one-hot");
  AST_WAKE_BITS: assert property (avs_read && !avs_waitrequest && avs_address == `CKG_WAKE_EN
      |-> avs_readdata[31:4] == 28'h0 && !avs_readdata[1])
    else $error("awake enable shows a bit for the clocks branch");
endmodule

// ==== tb/test_clock_generator_slice.sv ====
`timescale 1ns/10ps
`include "ckg_consts.svh"
module test_clock_generator_slice;
  logic                  core_clk;
  logic                  reset;
  logic [`CKG_AW-1:0]    avs_address;
  logic                  avs_read, avs_write, avs_waitrequest;
  logic [31:0]           avs_writedata, avs_readdata, rd;
  logic [3:0]            srcClk;
  logic                  core0Sleep, core1Sleep, dmaBusy, deepStop;
  logic                  refClk, sysClk, pinClockOutputA, systemSleep;
  logic [`CKG_NDEST-1:0] sysDestClk;
  int                    errTotal, samplesChecked, cycles;

  ckg_src_model src (.core_clk, .srcClk);
  ckg_top uut (.core_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .ringOscillator(srcClk[0]), .crystalOscillator(srcClk[1]),
    .pinClockInA(srcClk[2]), .pinClockInB(srcClk[3]), .core0Sleep, .core1Sleep, .dmaBusy,
    .deepStopState(deepStop), .refClk, .sysClk, .pinClockOutputA, .sysDestClk, .systemSleep);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic closeOut;
    $display("checks %0d errors %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samplesChecked++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task automatic busWr(input logic [`CKG_AW-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic busRd(input logic [`CKG_AW-1:0] a);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic rdChk(input logic [`CKG_AW-1:0] a, input logic [31:0] exp);
    busRd(a);
    chk(rd, exp, "register read");
  endtask

  task automatic waitPin(input logic lvl, inout int c);
    do begin
      @(posedge core_clk);
      c++;
    end while (pinClockOutputA !== lvl);
  endtask

  task automatic holdLow(input int n);
    repeat (n) begin
      @(posedge core_clk);
      chk({31'h0, pinClockOutputA}, 32'h0, "pin clock stopped");
    end
  endtask

  task automatic gateScan(input logic [3:0] exp);
    logic [3:0] seen;
    seen = 4'h0;
    // let the gates reload in a low phase before judging
    repeat (12) @(posedge core_clk);
    repeat (100) begin
      @(posedge core_clk);
      seen = seen | sysDestClk;
    end
    chk({28'h0, seen}, {28'h0, exp}, "gated destinations");
  endtask

  task automatic clkCase(input logic useSys, input int per);
    int c;
    c = 0;
    do @(posedge core_clk); while ((useSys ? sysClk : refClk) !== 1'b0);
    do @(posedge core_clk); while ((useSys ? sysClk : refClk) !== 1'b1);
    do begin
      @(posedge core_clk);
      c++;
    end while ((useSys ? sysClk : refClk) !== 1'b0);
    do begin
      @(posedge core_clk);
      c++;
    end while ((useSys ? sysClk : refClk) !== 1'b1);
    chk(32'(c), 32'(per), "always-on clock period");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic resetValues;
    rdChk(`CKG_REF_DIV, `CKG_DIV_RESET);
    rdChk(`CKG_SYS_DIV, `CKG_DIV_RESET);
    rdChk(`CKG_REF_SEL, 32'h1);
    rdChk(`CKG_SYS_SEL, 32'h1);
    rdChk(`CKG_WAKE_EN, 32'hd);
    rdChk(`CKG_SLEEP_EN, 32'hf);
    busWr(6'h2c, 32'hffff_ffff);
    rdChk(6'h2c, 32'h0);
    busWr(`CKG_PIN_DIV, 32'h0000_0512);
    rdChk(`CKG_PIN_DIV, 32'h0000_0512);
  endtask

  task automatic glitchMove(input logic [5:0] ca, input logic [5:0] sa,
                            input logic [31:0] ct, input logic [31:0] sel);
    int n;
    busWr(ca, ct);
    n = 0;
    do begin
      busRd(sa);
      n++;
    end while (rd !== sel && n < 100);
    chk(rd, sel, "selected source");
  endtask

  task automatic pinCase(input logic [31:0] dv, input logic [31:0] ct,
                         input int n, input int hi, input int per);
    int c;
    int h;
    busWr(`CKG_PIN_DIV, dv);
    busWr(`CKG_PIN_CTRL, ct);
    // the period in flight at the write may still use the old settings
    waitPin(1'b1, c);
    waitPin(1'b0, c);
    waitPin(1'b1, c);
    c = 0;
    waitPin(1'b0, c);
    h = c;
    waitPin(1'b1, c);
    repeat (n - 1) begin
      waitPin(1'b0, c);
      waitPin(1'b1, c);
    end
    if (hi > 0) chk(32'(h), 32'(hi), "high time");
    chk(32'(c), 32'(per), "period");
  endtask

  task automatic pinStop;
    int c;
    busWr(`CKG_PIN_CTRL, 32'h0);
    repeat (60) @(posedge core_clk);
    holdLow(30);
    busWr(`CKG_PIN_CTRL, 32'h20);
    busWr(`CKG_PIN_CTRL, 32'h820);
    waitPin(1'b1, c);
    busWr(`CKG_PIN_CTRL, 32'hc20);
    @(posedge core_clk);
    holdLow(20);
    busWr(`CKG_PIN_CTRL, 32'h0);
    pinCase(32'h300, 32'h820, 1, 12, 36);
  endtask

  task automatic sleepRun;
    gateScan(4'hf);
    busWr(`CKG_WAKE_EN, 32'h0);
    rdChk(`CKG_WAKE_EN, 32'h0);
    gateScan(4'h3);
    busWr(`CKG_SLEEP_EN, 32'h4);
    core0Sleep <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk({31'h0, systemSleep}, 32'h0, "one core awake");
    core1Sleep <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk({31'h0, systemSleep}, 32'h1, "both cores asleep");
    gateScan(4'h4);
    dmaBusy <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk({31'h0, systemSleep}, 32'h0, "dma outstanding");
    gateScan(4'h3);
    busWr(`CKG_WAKE_EN, 32'hf);
    busWr(`CKG_SLEEP_EN, 32'hf);
    dmaBusy <= 1'b0;
    gateScan(4'hf);
    core0Sleep <= 1'b0;
    core1Sleep <= 1'b0;
  endtask

  task automatic stopRun;
    deepStop <= 1'b1;
    repeat (60) @(posedge core_clk);
    repeat (20) begin
      @(posedge core_clk);
      chk({30'h0, sysClk, refClk}, 32'h0, "always-on clocks stopped");
    end
    deepStop <= 1'b0;
    clkCase(1'b0, 10);
    clkCase(1'b1, 10);
    rdChk(`CKG_STATUS, 32'he);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      $display("unexpected at %0t: run did not finish", $time);
      closeOut();
    end
  end

  initial begin
    reset = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    core0Sleep = 1'b0;
    core1Sleep = 1'b0;
    dmaBusy = 1'b0;
    deepStop = 1'b0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    resetValues();
    glitchMove(`CKG_REF_CTRL, `CKG_REF_SEL, 32'h1, 32'h2);
    glitchMove(`CKG_REF_CTRL, `CKG_REF_SEL, 32'h0, 32'h1);
    glitchMove(`CKG_SYS_CTRL, `CKG_SYS_SEL, 32'h1, 32'h2);
    glitchMove(`CKG_SYS_CTRL, `CKG_SYS_SEL, 32'h0, 32'h1);
    busWr(`CKG_SYS_CTRL, 32'h60);
    glitchMove(`CKG_SYS_CTRL, `CKG_SYS_SEL, 32'h61, 32'h2);
    glitchMove(`CKG_SYS_CTRL, `CKG_SYS_SEL, 32'h60, 32'h1);
    pinCase(32'h300, 32'h800, 1, 10, 30);
    pinCase(32'h300, 32'h1800, 1, 15, 30);
    pinCase(32'h400, 32'h1800, 1, 20, 40);
    pinCase(32'h100, 32'h800, 1, 0, 10);
    pinCase(32'h200, 32'h800, 1, 10, 20);
    pinCase(32'h280, 32'h800, 4, 0, 100);
    pinStop();
    busWr(`CKG_PIN_CTRL, 32'h0);
    repeat (100) @(posedge core_clk);
    pinCase(32'h100, 32'h860, 1, 0, 18);
    busWr(`CKG_PIN_CTRL, 32'h0);
    repeat (100) @(posedge core_clk);
    pinCase(32'h200, 32'h880, 1, 10, 20);
    sleepRun();
    stopRun();
    closeOut();
  end
endmodule

bind ckg_top ckg_top_checker watch (.core_clk, .reset, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .core0Sleep, .core1Sleep, .dmaBusy,
  .sysClk, .pinClockOutputA, .sysDestClk, .systemSleep);
